//--- src/spp_desc_decode.sv
`timescale 1ns/1ps
module spp_desc_decode
    import spp_pkg::*;
(
    input  wire logic               appDesc,
    input  wire logic [3:0]         typeCode,
    output logic      [CLS_W-1:0]   cls
);

    // Classify one descriptor type code
    always_comb
    begin
        cls = '0;
        if (appDesc)
        begin
            cls[CLS_ACCESSED] = typeCode[0];
            if (!typeCode[3])
            begin
                cls[CLS_DATA]     = 1'b1;
                cls[CLS_WRITABLE] = typeCode[1];
                cls[CLS_EXPDOWN]  = typeCode[2];
            end
            else
            begin
                cls[CLS_CODE]     = 1'b1;
                cls[CLS_READABLE] = typeCode[1];
                cls[CLS_CONFORM]  = typeCode[2];
            end
        end
        else
        begin
            cls[CLS_GATE32] = typeCode[3];
            case (typeCode)
                4'h1: cls[CLS_TASK16] = 1'b1;
                4'h2: cls[CLS_LOCAL] = 1'b1;
                4'h3:
                begin
                    cls[CLS_TASK16]   = 1'b1;
                    cls[CLS_TASKBUSY] = 1'b1;
                end
                4'h9: cls[CLS_TASK32] = 1'b1;
                4'hb:
                begin
                    cls[CLS_TASK32]   = 1'b1;
                    cls[CLS_TASKBUSY] = 1'b1;
                end
                4'h4, 4'hc: cls[CLS_CALLGATE] = 1'b1;
                4'h5: cls[CLS_TASKGATE] = 1'b1;
                4'h6, 4'he: cls[CLS_INTGATE] = 1'b1;
                4'h7, 4'hf: cls[CLS_TRAPGATE] = 1'b1;
                default: cls[CLS_RESERVED] = 1'b1;
            endcase
            // Reserved system types carry no width bit
            cls[CLS_GATE32] = typeCode[3] & ~cls[CLS_RESERVED];
        end
    end

endmodule : spp_desc_decode

//--- src/spp_pkg.sv
package spp_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL_ZERO    = 8'h00;
    localparam logic [7:0] OFS_CTRL_FOUR    = 8'h04;
    localparam logic [7:0] OFS_GLOBAL_BASE  = 8'h08;
    localparam logic [7:0] OFS_INT_BASE     = 8'h0c;
    localparam logic [7:0] OFS_LOCAL_TABLE  = 8'h10;
    localparam logic [7:0] OFS_TASK_BLOCK   = 8'h14;
    localparam logic [7:0] OFS_IRQ_STATUS   = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK     = 8'h1c;
    localparam logic [7:0] OFS_DESC_PROBE   = 8'h20;
    localparam logic [7:0] OFS_DESC_CLASS   = 8'h24;
    localparam logic [7:0] OFS_LAST_VECTOR  = 8'h28;
    localparam logic [7:0] OFS_PHYS_ADDR    = 8'h2c;

    // Control bits
    localparam int         CTRL_ALIGN_MASK_BIT = 18;
    localparam int         CTRL_LARGE_PAGE_BIT = 4;
    localparam logic       RST_ALIGN_MASK      = 1'b0;
    localparam logic       RST_LARGE_PAGE      = 1'b0;
    localparam logic [31:0] RST_WORD           = 32'h0000_0000;

    // Page entry bit positions
    localparam int PG_PRESENT  = 0;
    localparam int PG_WRITABLE = 1;
    localparam int PG_USER     = 2;
    localparam int PG_SIZE_SEL = 7;
    localparam int LARGE_SHIFT = 22;
    localparam int SMALL_SHIFT = 12;

    // Class word bits
    localparam int CLS_W        = 17;
    localparam int CLS_DATA     = 0;
    localparam int CLS_CODE     = 1;
    localparam int CLS_ACCESSED = 2;
    localparam int CLS_WRITABLE = 3;
    localparam int CLS_READABLE = 4;
    localparam int CLS_EXPDOWN  = 5;
    localparam int CLS_CONFORM  = 6;
    localparam int CLS_TASK16   = 7;
    localparam int CLS_TASK32   = 8;
    localparam int CLS_TASKBUSY = 9;
    localparam int CLS_LOCAL    = 10;
    localparam int CLS_CALLGATE = 11;
    localparam int CLS_TASKGATE = 12;
    localparam int CLS_INTGATE  = 13;
    localparam int CLS_TRAPGATE = 14;
    localparam int CLS_RESERVED = 15;
    localparam int CLS_GATE32   = 16;

    // Exception vector numbers
    localparam int VEC_DIVIDE   = 0;
    localparam int VEC_DEBUG    = 1;
    localparam int VEC_NMI      = 2;
    localparam int VEC_BREAK    = 3;
    localparam int VEC_OVERFLOW = 4;
    localparam int VEC_BOUNDS   = 5;
    localparam int VEC_OPCODE   = 6;
    localparam int VEC_NODEVICE = 7;
    localparam int VEC_DOUBLE   = 8;
    localparam int VEC_BADTASK  = 10;
    localparam int VEC_NOTPRES  = 11;
    localparam int VEC_STACK    = 12;
    localparam int VEC_GENPROT  = 13;
    localparam int VEC_PAGE     = 14;
    localparam int VEC_FLOAT    = 16;
    localparam int VEC_ALIGN    = 17;
    localparam logic [31:0] FAULT_SET = 32'h0003_7ce1;
    localparam logic [31:0] VEC_LEGAL = 32'h0003_7dff;

    // Whole state of the checker
    typedef struct packed {
        logic              alignMaskBit;
        logic              largePageEnable;
        logic [31:0]       globalTableBase;
        logic [31:0]       intTableBase;
        logic [31:0]       localTable;
        logic [31:0]       taskStateBlock;
        logic [31:0]       status;
        logic [31:0]       mask;
        logic [31:0]       pending;
        logic [4:0]        descProbe;
        logic              handling;
        logic [2:0]        nmiSync;
        logic              vecValid;
        logic [7:0]        vecNum;
        logic              irq;
        logic [31:0]       physAddr;
        logic              largeTlbSel;
        logic              xlateDone;
        logic              ack;
        logic [31:0]       datOut;
    } spp_state_t;

endpackage : spp_pkg

//--- src/spp_protect_check.sv
`timescale 1ns/1ps
module spp_protect_check
    import spp_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          ce,
    // Wishbone slave
    input  wire logic          wbCyc,
    input  wire logic          wbStb,
    input  wire logic          wbWe,
    input  wire logic [7:0]    wbAdr,
    input  wire logic [3:0]    wbSel,
    input  wire logic [31:0]   wbDatI,
    output logic      [31:0]   wbDatO,
    output logic               wbAck,
    // Fault sources from the pipeline
    input  wire logic          divErr,
    input  wire logic          debugEvt,
    input  wire logic          nmiPin,
    input  wire logic          breakInstr,
    input  wire logic          overflowInstr,
    input  wire logic          boundsFail,
    input  wire logic          badOpcode,
    input  wire logic          coprocessorOpcode,
    input  wire logic          fpError,
    input  wire logic          unalignedRef,
    input  wire logic          alignCheckFlag,
    input  wire logic          genProtReq,
    input  wire logic          handlerDone,
    // Segment load and task switch checks
    input  wire logic          segLoad,
    input  wire logic          segApp,
    input  wire logic [3:0]    segType,
    input  wire logic          segPresent,
    input  wire logic          segIsStack,
    input  wire logic          stackLimitViol,
    input  wire logic          taskSwitch,
    input  wire logic [3:0]    taskType,
    // Page translation
    input  wire logic          xlateReq,
    input  wire logic [31:0]   linearAddr,
    input  wire logic [31:0]   directoryEntry,
    input  wire logic [31:0]   tableEntry,
    input  wire logic          writeAccess,
    input  wire logic          userAccess,
    output logic      [31:0]   physAddr,
    output logic               largeTlbSel,
    output logic               xlateDone,
    // Table pointers and exception dispatch
    output logic      [31:0]   globalTableBase,
    output logic      [31:0]   intTableBase,
    output logic      [31:0]   localTable,
    output logic      [31:0]   taskStateBlock,
    output logic               vecValid,
    output logic      [7:0]    vecNum,
    output logic               irq
);

    spp_state_t s;
    spp_state_t next_s;

    logic [CLS_W-1:0] cls [3];
    logic [3:0]       decType [3];
    logic             decApp [3];

    // Decoder sources
    assign decType[0] = s.descProbe[3:0];
    assign decApp[0]  = s.descProbe[4];
    assign decType[1] = segType;
    assign decApp[1]  = segApp;
    assign decType[2] = taskType;
    assign decApp[2]  = 1'b0;

    // One type decoder per descriptor source
    generate
        for (genvar g = 0; g < 3; g++)
        begin : gDec
            spp_desc_decode uDec (
                .appDesc  (decApp[g]),
                .typeCode (decType[g]),
                .cls      (cls[g])
            );
        end
    endgenerate

    // Byte-lane merge of a write
    function automatic logic [31:0] laneMerge(
        input logic [31:0] oldVal,
        input logic [31:0] newVal,
        input logic [3:0]  sel
    );
        logic [31:0] r;
        r = oldVal;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
                r[b*8 +: 8] = newVal[b*8 +: 8];
        end
        return r;
    endfunction : laneMerge

    // Next-state logic
    always_comb
    begin
        logic [31:0] ev;
        logic [31:0] cand;
        logic [31:0] wr;
        logic [31:0] clr;
        logic [31:0] perm;
        logic        busWrite;
        logic        newReq;
        logic        largePath;
        logic        pgFault;
        logic        found;
        logic [4:0]  pick;
        ev        = '0;
        cand      = '0;
        wr        = '0;
        clr       = '0;
        perm      = '0;
        busWrite  = 1'b0;
        newReq    = 1'b0;
        largePath = 1'b0;
        pgFault   = 1'b0;
        found     = 1'b0;
        pick      = '0;
        next_s    = s;

        // Pin sync
        next_s.nmiSync = {s.nmiSync[1:0], nmiPin};

        // Simple condition inputs
        ev[VEC_DIVIDE]   = divErr;
        ev[VEC_DEBUG]    = debugEvt;
        ev[VEC_NMI]      = s.nmiSync[1] & ~s.nmiSync[2];
        ev[VEC_BREAK]    = breakInstr;
        ev[VEC_OVERFLOW] = overflowInstr;
        ev[VEC_BOUNDS]   = boundsFail;
        ev[VEC_OPCODE]   = badOpcode;
        ev[VEC_NODEVICE] = coprocessorOpcode;
        ev[VEC_FLOAT]    = fpError;
        ev[VEC_ALIGN]    = unalignedRef & alignCheckFlag & s.alignMaskBit;
        ev[VEC_GENPROT]  = genProtReq;
        ev[VEC_STACK]    = stackLimitViol;

        // Segment load checks
        if (segLoad)
        begin
            if (!segPresent)
            begin
                if (segIsStack)
                    ev[VEC_STACK] = 1'b1;
                else
                    ev[VEC_NOTPRES] = 1'b1;
            end
            else if (!segApp || cls[1][CLS_RESERVED])
                ev[VEC_GENPROT] = 1'b1;
            else if (segIsStack && !cls[1][CLS_WRITABLE])
                ev[VEC_GENPROT] = 1'b1;
            else if (cls[1][CLS_CODE] && !cls[1][CLS_READABLE])
                ev[VEC_GENPROT] = 1'b1;
        end

        // Task switch target must be a task block
        if (taskSwitch && !(cls[2][CLS_TASK16] | cls[2][CLS_TASK32]))
            ev[VEC_BADTASK] = 1'b1;

        // Page translation
        next_s.xlateDone = 1'b0;
        if (xlateReq)
        begin
            largePath = s.largePageEnable & directoryEntry[PG_SIZE_SEL];
            perm = largePath ? directoryEntry : (directoryEntry & tableEntry);
            if (!directoryEntry[PG_PRESENT])
                pgFault = 1'b1;
            else if (!largePath && !tableEntry[PG_PRESENT])
                pgFault = 1'b1;
            else if (userAccess && !perm[PG_USER])
                pgFault = 1'b1;
            else if (userAccess && writeAccess && !perm[PG_WRITABLE])
                pgFault = 1'b1;
            ev[VEC_PAGE] = pgFault;
            if (!pgFault)
            begin
                next_s.xlateDone   = 1'b1;
                next_s.largeTlbSel = largePath;
                if (largePath)
                    next_s.physAddr = {directoryEntry[31:LARGE_SHIFT],
                                       linearAddr[LARGE_SHIFT-1:0]};
                else
                    next_s.physAddr = {tableEntry[31:SMALL_SHIFT],
                                       linearAddr[SMALL_SHIFT-1:0]};
            end
        end

        // Dispatch one vector per cycle, lowest number first
        ev   = ev & VEC_LEGAL;
        cand = s.pending | ev;
        next_s.vecValid = 1'b0;
        if (s.handling && ((cand & FAULT_SET) != '0))
        begin
            next_s.vecValid = 1'b1;
            next_s.vecNum   = 8'(VEC_DOUBLE);
            ev[VEC_DOUBLE]  = 1'b1;
            cand            = cand & ~FAULT_SET;
        end
        else
        begin
            for (int v = 31; v >= 0; v--)
            begin
                if (cand[v])
                begin
                    found = 1'b1;
                    pick  = 5'(v);
                end
            end
            if (found)
            begin
                next_s.vecValid = 1'b1;
                next_s.vecNum   = {3'h0, pick};
                cand[pick]      = 1'b0;
                if (FAULT_SET[pick])
                    next_s.handling = 1'b1;
            end
        end
        next_s.pending = cand;
        if (handlerDone && !next_s.vecValid)
            next_s.handling = 1'b0;

        // Wishbone: answer one cycle after the request
        newReq       = wbCyc & wbStb & ~s.ack;
        busWrite     = wbCyc & wbStb & wbWe & s.ack;
        next_s.ack   = newReq;
        wr           = laneMerge(RST_WORD, wbDatI, wbSel);
        if (newReq && !wbWe)
        begin
            case (wbAdr)
                OFS_CTRL_ZERO:   next_s.datOut = 32'(s.alignMaskBit) << CTRL_ALIGN_MASK_BIT;
                OFS_CTRL_FOUR:   next_s.datOut = 32'(s.largePageEnable) << CTRL_LARGE_PAGE_BIT;
                OFS_GLOBAL_BASE: next_s.datOut = s.globalTableBase;
                OFS_INT_BASE:    next_s.datOut = s.intTableBase;
                OFS_LOCAL_TABLE: next_s.datOut = s.localTable;
                OFS_TASK_BLOCK:  next_s.datOut = s.taskStateBlock;
                OFS_IRQ_STATUS:  next_s.datOut = s.status;
                OFS_IRQ_MASK:    next_s.datOut = s.mask;
                OFS_DESC_PROBE:  next_s.datOut = {27'h0, s.descProbe};
                OFS_DESC_CLASS:  next_s.datOut = {15'h0, cls[0]};
                OFS_LAST_VECTOR: next_s.datOut = {23'h0, s.handling, s.vecNum};
                OFS_PHYS_ADDR:   next_s.datOut = s.physAddr;
                default:         next_s.datOut = RST_WORD;
            endcase
        end

        // Writes land one cycle after ack
        if (busWrite)
        begin
            case (wbAdr)
                OFS_CTRL_ZERO:
                    if (wbSel[CTRL_ALIGN_MASK_BIT/8])
                        next_s.alignMaskBit = wbDatI[CTRL_ALIGN_MASK_BIT];
                OFS_CTRL_FOUR:
                    if (wbSel[CTRL_LARGE_PAGE_BIT/8])
                        next_s.largePageEnable = wbDatI[CTRL_LARGE_PAGE_BIT];
                OFS_GLOBAL_BASE:
                    next_s.globalTableBase = laneMerge(s.globalTableBase, wbDatI, wbSel);
                OFS_INT_BASE:
                    next_s.intTableBase = laneMerge(s.intTableBase, wbDatI, wbSel);
                OFS_LOCAL_TABLE:
                    next_s.localTable = laneMerge(s.localTable, wbDatI, wbSel);
                OFS_TASK_BLOCK:
                    next_s.taskStateBlock = laneMerge(s.taskStateBlock, wbDatI, wbSel);
                OFS_IRQ_STATUS:  clr = wr;
                OFS_IRQ_MASK:    next_s.mask = laneMerge(s.mask, wbDatI, wbSel) & VEC_LEGAL;
                OFS_DESC_PROBE:
                    if (wbSel[0])
                        next_s.descProbe = wbDatI[4:0];
                default: ;
            endcase
        end

        // Sticky status, a new event beats the clear
        next_s.status = ((s.status & ~clr) | ev) & VEC_LEGAL;
        next_s.irq    = (next_s.status & next_s.mask) != '0;
    end

    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s                 <= '0;
            s.alignMaskBit    <= RST_ALIGN_MASK;
            s.largePageEnable <= RST_LARGE_PAGE;
        end
        else if (ce)
        begin
            s <= next_s;
        end
    end

    // Registered outputs
    assign wbDatO          = s.datOut;
    assign wbAck           = s.ack;
    assign physAddr        = s.physAddr;
    assign largeTlbSel     = s.largeTlbSel;
    assign xlateDone       = s.xlateDone;
    assign globalTableBase = s.globalTableBase;
    assign intTableBase    = s.intTableBase;
    assign localTable      = s.localTable;
    assign taskStateBlock  = s.taskStateBlock;
    assign vecValid        = s.vecValid;
    assign vecNum          = s.vecNum;
    assign irq             = s.irq;

endmodule : spp_protect_check

//--- testbench/spp_pipe_model.sv
`timescale 1ns/1ps
module spp_pipe_model (
    input  wire logic        clk,
    input  wire logic [10:0] req,
    output logic             divErr,
    output logic             debugEvt,
    output logic             breakInstr,
    output logic             overflowInstr,
    output logic             boundsFail,
    output logic             badOpcode,
    output logic             coprocessorOpcode,
    output logic             fpError,
    output logic             genProtReq,
    output logic             stackLimitViol,
    output logic             handlerDone
);
    logic [10:0] q = 11'h000;

    // Registered event pulses
    always_ff @(posedge clk)
    begin
        q <= req;
    end

    // Fault, trap and handler-end pulses of the pipeline
    assign {handlerDone, stackLimitViol, genProtReq, fpError, coprocessorOpcode, badOpcode,
            boundsFail, overflowInstr, breakInstr, debugEvt, divErr} = q;
endmodule : spp_pipe_model

//--- testbench/spp_protect_check_sva.sv
`timescale 1ns/1ps
module spp_protect_check_sva (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic        wbCyc,
    input wire logic        wbStb,
    input wire logic        wbWe,
    input wire logic        wbAck,
    input wire logic        nmiPin,
    input wire logic        xlateReq,
    input wire logic [31:0] linearAddr,
    input wire logic [31:0] directoryEntry,
    input wire logic [31:0] tableEntry,
    input wire logic [31:0] physAddr,
    input wire logic        largeTlbSel,
    input wire logic        xlateDone,
    input wire logic [31:0] globalTableBase,
    input wire logic        vecValid,
    input wire logic [7:0]  vecNum
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_ack; ce && wbCyc && wbStb && !wbAck |=> wbAck; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_ackDrop; wbAck |=> !wbAck; endproperty
    a_ackDrop: assert property (p_ackDrop) else $error("long ack");
    property p_ptr; !(wbCyc && wbStb && wbWe && wbAck) |=> $stable(globalTableBase); endproperty
    a_ptr: assert property (p_ptr) else $error("pointer moved");
    property p_vec; vecValid |-> vecNum <= 8'h11 && vecNum != 8'h09 && vecNum != 8'h0f; endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_nmi; $rose(nmiPin) |-> ##[2:20] (vecValid && vecNum == 8'h02); endproperty
    a_nmi: assert property (p_nmi) else $error("no vector 2");
    property p_done; xlateDone |-> $past(xlateReq); endproperty
    a_done: assert property (p_done) else $error("stray done");
    property p_large;
        xlateDone && largeTlbSel |-> ($past(directoryEntry) & 32'h0000_0080) != 32'h0;
    endproperty
    a_large: assert property (p_large) else $error("large w/o size bit");
    property p_lgAddr;
        xlateDone && largeTlbSel |-> ((physAddr ^ $past(linearAddr)) & 32'h003f_ffff) == 32'h0
            && ((physAddr ^ $past(directoryEntry)) & 32'hffc0_0000) == 32'h0;
    endproperty
    a_lgAddr: assert property (p_lgAddr) else $error("bad large address");
    property p_smAddr;
        xlateDone && !largeTlbSel |-> ((physAddr ^ $past(linearAddr)) & 32'h0000_0fff) == 32'h0
            && ((physAddr ^ $past(tableEntry)) & 32'hffff_f000) == 32'h0;
    endproperty
    a_smAddr: assert property (p_smAddr) else $error("bad small address");

    // Main scenarios reached
    c_double: cover property (vecValid && vecNum == 8'h08);
    c_large: cover property (xlateDone && largeTlbSel);
    c_read: cover property (wbAck && !wbWe);
endmodule : spp_protect_check_sva

bind spp_protect_check spp_protect_check_sva chk_u (.*);

//--- testbench/test_segment_page_protection_check.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module test_segment_page_protection_check;
    import spp_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
    logic        wbAck, irq, vecValid, largeTlbSel, xlateDone, nmiPin = 1'b0;
    logic [3:0]  wbSel = 4'h0, segType = 4'h0, taskType = 4'h0;
    logic [7:0]  wbAdr = 8'h00, vecNum, ve;
    logic [31:0] wbDatI = '0, linearAddr = '0, directoryEntry = '0, tableEntry = '0;
    logic [31:0] wbDatO, physAddr, globalTableBase, intTableBase, localTable, taskStateBlock;
    logic        unalignedRef = 1'b0, alignCheckFlag = 1'b0, segLoad = 1'b0, segApp = 1'b0;
    logic        segPresent = 1'b0, segIsStack = 1'b0, taskSwitch = 1'b0, xlateReq = 1'b0;
    logic        writeAccess = 1'b0, userAccess = 1'b0, divErr, debugEvt, breakInstr;
    logic        overflowInstr, boundsFail, badOpcode, coprocessorOpcode, fpError;
    logic        genProtReq, stackLimitViol, handlerDone;
    logic [10:0] req = '0;
    logic [7:0]  vq[$];
    logic [63:0] rq[$], re;
    logic [32:0] xq[$], xe;
    logic [31:0] stat = '0, d;
    logic [127:0] pp;
    logic [7:0]  vt[10] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h10, 8'h0d, 8'h0c};
    int          fails = 0, cmp_count = 0, cyc = 0, s;

    spp_protect_check dut_u (.*);
    spp_pipe_model    pipe_u (.*);

    // Free-running core clock
    initial forever #20 clk = ~clk;

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    // Classic cycle held until ack, then idle
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] dw);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= a;
        wbSel <= 4'hf;
        wbDatI <= dw;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wbAck !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            fails++;
            final_report();
        end
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        rq.push_back({m, e});
        wb(a, 1'b0, '0);
    endtask : rd

    task automatic ev(input logic [10:0] m);
        req <= m;
        @(posedge clk);
        req <= '0;
    endtask : ev

    task automatic hd;
        ev(11'h400);
        idle(2);
    endtask : hd

    task automatic fault(input int i);
        vq.push_back(vt[i]);
        stat[vt[i][4:0]] = 1'b1;
        ev(11'(1 << i));
        idle(3);
        hd();
    endtask : fault

    // k: 0 load, 1 switch, 2 unaligned
    task automatic load(input logic [1:0] k, input logic [3:0] t, input logic [2:0] f,
                        input logic [7:0] v);
        segApp <= f[2];
        alignCheckFlag <= f[2];
        segPresent <= f[1];
        segIsStack <= f[0];
        segType <= t;
        taskType <= t;
        segLoad <= (k == 2'd0);
        taskSwitch <= (k == 2'd1);
        unalignedRef <= (k == 2'd2);
        @(posedge clk);
        segLoad <= 1'b0;
        taskSwitch <= 1'b0;
        unalignedRef <= 1'b0;
        if (v != 8'hff)
        begin
            vq.push_back(v);
            stat[v[4:0]] = 1'b1;
        end
        idle(3);
        hd();
    endtask : load

    // Translation; pb = present, writable, user
    task automatic xl(input logic en, input logic lg, input logic [2:0] pb);
        logic [31:0] dr, tb, la;
        dr = ($urandom & 32'hffff_ff78) | {24'h0, lg, 4'h0, pb};
        tb = $urandom | 32'h7;
        la = $urandom;
        if (pb != 3'h7)
        begin
            vq.push_back(8'h0e);
            stat[14] = 1'b1;
        end
        else if (en && lg)
            xq.push_back({1'b1, dr[31:22], la[21:0]});
        else
            xq.push_back({1'b0, tb[31:12], la[11:0]});
        directoryEntry <= dr;
        tableEntry <= tb;
        linearAddr <= la;
        writeAccess <= 1'($urandom);
        userAccess <= 1'b1;
        xlateReq <= 1'b1;
        @(posedge clk);
        xlateReq <= 1'b0;
        idle(3);
        hd();
    endtask : xl

    function automatic logic [31:0] cls_exp(input logic a, input logic [3:0] t);
        logic [31:0] c;
        c = '0;
        if (a)
        begin
            c[t[3]] = 1'b1;
            c[2] = t[0];
            c[t[3] ? 4 : 3] = t[1];
            c[t[3] ? 6 : 5] = t[2];
        end
        else
        begin
            case (t)
                4'h1: c[7] = 1'b1;
                4'h3: c[9:7] = 3'b101;
                4'h9: c[8] = 1'b1;
                4'hb: c[9:8] = 2'b11;
                4'h2: c[10] = 1'b1;
                4'h4, 4'hc: c[11] = 1'b1;
                4'h5: c[12] = 1'b1;
                4'h6, 4'he: c[13] = 1'b1;
                4'h7, 4'hf: c[14] = 1'b1;
                default: c[15] = 1'b1;
            endcase
            c[16] = t[3] & |c[14:11];
        end
        return c;
    endfunction : cls_exp

    // Scoreboard: oldest note per answer
    always @(posedge clk)
    begin
        if (!rst && vecValid === 1'b1)
        begin
            ve = (vq.size() > 0) ? vq.pop_front() : 8'hff;
            `CHK("vecNum", ve, vecNum)
        end
        if (!rst && wbAck === 1'b1 && wbWe === 1'b0)
        begin
            re = (rq.size() > 0) ? rq.pop_front() : '1;
            `CHK("wbDatO", re[31:0], wbDatO & re[63:32])
        end
        if (!rst && xlateDone === 1'b1)
        begin
            xe = (xq.size() > 0) ? xq.pop_front() : '1;
            `CHK("xlate", xe, {largeTlbSel, physAddr})
        end
    end

    // Cuts a hang short
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            final_report();
        end
    end

    initial
    begin
        s = $urandom(93847);
        idle(5);
        rst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 16; a++)
            rd(8'(a * 4), (a == 9) ? 32'h0000_8000 : 32'h0, '1);
        for (int i = 0; i < 4; i++)
        begin
            d = $urandom;
            wb(OFS_GLOBAL_BASE + 8'(i * 4), 1'b1, d);
            rd(OFS_GLOBAL_BASE + 8'(i * 4), d, '1);
            pp = {taskStateBlock, localTable, intTableBase, globalTableBase};
            `CHK("pointer", d, pp[i * 32 +: 32])
        end
        for (int k = 0; k < 32; k++)
        begin
            wb(OFS_DESC_PROBE, 1'b1, 32'(k));
            rd(OFS_DESC_CLASS, cls_exp(k[4], k[3:0]), (k == 9 || k == 11) ? 32'hfffe_ffff : '1);
        end
        for (int i = 0; i < 10; i++)
            fault(i);
        vq = {vq, 8'h01, 8'h03, 8'h04};
        ev(11'h00e);
        idle(4);
        vq = {vq, 8'h00, 8'h08};
        stat[8] = 1'b1;
        ev(11'h001);
        idle(3);
        ev(11'h020);
        idle(3);
        hd();
        // Frozen clock enable drops the pulse: no vector may appear
        ce <= 1'b0;
        ev(11'h001);
        idle(2);
        ce <= 1'b1;
        vq.push_back(8'h02);
        stat[2] = 1'b1;
        nmiPin <= 1'b1;
        idle(8);
        nmiPin <= 1'b0;
        idle(2);
        load(2'd2, 4'h0, 3'b100, 8'hff);
        wb(OFS_CTRL_ZERO, 1'b1, 32'h0004_0000);
        load(2'd2, 4'h0, 3'b100, 8'h11);
        load(2'd2, 4'h0, 3'b000, 8'hff);
        load(2'd0, 4'h2, 3'b100, 8'h0b);
        load(2'd0, 4'h2, 3'b101, 8'h0c);
        load(2'd0, 4'h2, 3'b111, 8'hff);
        load(2'd0, 4'h0, 3'b111, 8'h0d);
        load(2'd0, 4'h8, 3'b110, 8'h0d);
        load(2'd0, 4'h2, 3'b010, 8'h0d);
        load(2'd1, 4'h2, 3'b010, 8'h0a);
        load(2'd1, 4'h9, 3'b010, 8'hff);
        wb(OFS_CTRL_FOUR, 1'b1, 32'h0000_0010);
        xl(1'b1, 1'b1, 3'h7);
        xl(1'b1, 1'b0, 3'h7);
        xl(1'b1, 1'b1, 3'h3);
        xl(1'b1, 1'b0, 3'h6);
        wb(OFS_CTRL_FOUR, 1'b1, 32'h0);
        xl(1'b0, 1'b1, 3'h7);
        rd(OFS_IRQ_STATUS, stat, '1);
        `CHK("irq", 1'b0, irq)
        wb(OFS_IRQ_MASK, 1'b1, stat);
        idle(1);
        `CHK("irq", 1'b1, irq)
        wb(OFS_IRQ_STATUS, 1'b1, stat);
        idle(1);
        `CHK("irq", 1'b0, irq)
        rd(OFS_IRQ_STATUS, 32'h0, '1);
        idle(5);
        `CHK("queues", 32'h0, 32'(vq.size() + rq.size() + xq.size()))
        final_report();
    end
endmodule : test_segment_page_protection_check
